// ### rtl/cfg_fuse_pkg.sv
// Constants, types and decode helpers shared by the configuration fuse decoder.
package cfg_fuse_pkg;
    // ----------------------------------------
    // Byte addresses and reset values
    // ----------------------------------------
    localparam logic [21:0] ADDR_CFG3 = 22'h30_0002;
    localparam logic [21:0] ADDR_CFG4 = 22'h30_0003;
    localparam logic [21:0] ADDR_CFG5 = 22'h30_0004;
    localparam logic [5:0] CFG3_RESET = 6'h3f;
    localparam logic [7:0] CFG4_RESET = 8'hbf;
    localparam logic [7:0] CFG4_MASK = 8'hbf;
    localparam logic [7:0] CFG5_RESET = 8'h7f;
    localparam logic [7:0] CFG5_MASK = 8'h7f;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int B3_LPBOR = 5;
    localparam int B3_VT1W = 4;
    localparam int B3_MVEC = 3;
    localparam int B3_PUT = 1;
    localparam int B3_RSTPIN = 0;
    localparam int B4_ISA_OFF = 7;
    localparam int B4_LVPROG = 5;
    localparam int B4_STK = 4;
    localparam int B4_PS1W = 3;
    localparam int B4_ZC = 2;
    localparam int B4_BOR = 0;
    localparam int B5_WDMODE = 5;

    // ----------------------------------------
    // Power-up timer timing
    // ----------------------------------------
    localparam logic [1:0] PUT_OFF = 2'h3;
    localparam logic [1:0] PUT_LONG = 2'h2;
    localparam logic [1:0] PUT_MID = 2'h1;
    localparam int PUT_LONG_MS = 64;
    localparam int PUT_MID_MS = 16;
    localparam int PUT_SHORT_MS = 1;
    localparam int CLK_KHZ = 100000;
    localparam int PUT_LONG_CYC = PUT_LONG_MS * CLK_KHZ;
    localparam int PUT_MID_CYC = PUT_MID_MS * CLK_KHZ;
    localparam int PUT_SHORT_CYC = PUT_SHORT_MS * CLK_KHZ;

    // ----------------------------------------
    // Brown-out trip levels in millivolts
    // ----------------------------------------
    localparam logic [11:0] BOR_MV_3 = 12'h76c;
    localparam logic [11:0] BOR_MV_2 = 12'h992;
    localparam logic [11:0] BOR_MV_1 = 12'ha8c;
    localparam logic [11:0] BOR_MV_0 = 12'hb22;

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    typedef enum logic [1:0] {
        WDT_OFF = 2'h0,
        WDT_SOFT = 2'h1,
        WDT_AWAKE = 2'h2,
        WDT_ALWAYS = 2'h3
    } wdt_mode_t;
    localparam logic [4:0] WDT_CPS_MAX_DIRECT = 5'h12;
    localparam logic [4:0] WDT_CPS_SOFT = 5'h1f;
    localparam logic [4:0] WDT_PS_DEFAULT = 5'h0b;
    localparam logic [4:0] WDT_LOG2_MIN = 5'h05;

    typedef enum logic [2:0] {
        PU_IDLE = 3'h1,
        PU_COUNT = 3'h2,
        PU_DONE = 3'h4
    } pu_state_t;

    // Prescale exponent for a period code; the reserved band falls back to 1:32.
    function automatic logic [4:0] wdt_log2(input logic [4:0] code);
        return (code <= WDT_CPS_MAX_DIRECT) ? 5'(code + WDT_LOG2_MIN) : WDT_LOG2_MIN;
    endfunction
endpackage

// ### rtl/cfg_lock_cell.sv
// One software lock bit with an optional one-way behaviour.
`timescale 1ns/1ps
`default_nettype none
module cfg_lock_cell (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic one_way,
    input wire logic unlock,
    input wire logic wr,
    input wire logic wdata,
    output logic lock
);
    typedef struct packed {
        logic locked;
        logic armed;
        logic spent;
    } cell_t;

    cell_t st;
    cell_t next_st;

    // An unlock arms a single write; a one-way lock that was set is spent for good.
    // The write is judged first, so an unlock in the same cycle re-arms and is not lost.
    always_comb begin
        next_st = st;
        if (wr && st.armed && !st.spent) begin
            next_st.locked = wdata;
            next_st.armed = 1'b0;
            next_st.spent = one_way && wdata;
        end
        if (unlock) begin
            next_st.armed = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lock = st.locked;

    property p_one_way;
        @(posedge clk) disable iff (!rst_b)
        (st.spent && st.locked) |=> ##1 (lock && st.spent);
    endproperty
    a_one_way: assert property (p_one_way) else $error("one-way lock released");
endmodule // cfg_lock_cell
`default_nettype wire

// ### rtl/config_fuse_decode.sv
// Configuration byte store and decoder for the system and watchdog options.
`timescale 1ns/1ps
`default_nettype none
module config_fuse_decode #(
    parameter int unsigned PUT_LONG_CYCLES = cfg_fuse_pkg::PUT_LONG_CYC,
    parameter int unsigned PUT_MID_CYCLES = cfg_fuse_pkg::PUT_MID_CYC,
    parameter int unsigned PUT_SHORT_CYCLES = cfg_fuse_pkg::PUT_SHORT_CYC
) (
    input wire logic MCLK,
    input wire logic RST_B,
    // Programmer side.
    input wire logic PROG_WE,
    input wire logic [21:0] PROG_ADDR,
    input wire logic [7:0] PROG_WDATA,
    input wire logic PROG_LV_ACTIVE,
    input wire logic PROG_DONE,
    output logic [7:0] PROG_RDATA,
    // Run-time controls.
    input wire logic SLEEP,
    input wire logic WATCHDOG_SW_ENABLE,
    input wire logic WATCHDOG_PERIOD_WE,
    input wire logic [4:0] WATCHDOG_PERIOD_WDATA,
    input wire logic VECTOR_UNLOCK,
    input wire logic VECTOR_LOCK_WE,
    input wire logic VECTOR_LOCK_WDATA,
    input wire logic PINSELECT_UNLOCK,
    input wire logic PINSELECT_LOCK_WE,
    input wire logic PINSELECT_LOCK_WDATA,
    input wire logic ZERO_CROSS_SW_ENABLE,
    input wire logic ZERO_CROSS_MODULE_DISABLE,
    input wire logic STACK_FAULT,
    // Decoded settings.
    output logic LOW_POWER_BROWNOUT_ON,
    output logic VECTOR_TABLE_LOCK,
    output logic PINSELECT_LOCK,
    output logic VECTOR_DISPATCH,
    output logic POWERUP_TIMER_DONE,
    output logic RESET_PIN_IS_RESET,
    output logic HV_ENTRY_REQUIRED,
    output logic EXTENDED_ISA_ON,
    output logic STACK_FAULT_RESET,
    output logic ZERO_CROSS_ON,
    output logic [11:0] BROWNOUT_MV,
    output logic WATCHDOG_RUN,
    output logic [4:0] WATCHDOG_PERIOD_SW,
    output logic WATCHDOG_PS_SW_OK,
    output logic [4:0] WATCHDOG_PRESCALE_LOG2
);
    typedef struct packed {
        logic load;
        logic [5:0] c3;
        logic [7:0] c4;
        logic [7:0] c5;
        logic [7:0] rdata;
        logic lp_bor_n;
        logic vt_1way;
        logic mvec;
        logic [1:0] put_sel;
        logic rst_pin_en;
        logic isa_dis;
        logic lv_prog;
        logic stk_rst;
        logic ps_1way;
        logic zc_dis;
        logic [1:0] bor_sel;
        cfg_fuse_pkg::wdt_mode_t wdt_mode;
        logic [4:0] cps;
        logic [4:0] wps;
        logic ps_sw_ok;
        logic [4:0] ps_log2;
        cfg_fuse_pkg::pu_state_t pu;
        logic [22:0] pu_cnt;
        logic lp_bor_on;
        logic dispatch;
        logic rst_is_rst;
        logic hv_req;
        logic isa_on;
        logic stk_pulse;
        logic zc_on;
        logic [11:0] bor_mv;
        logic wdt_run;
    } state_t;

    // Erased bytes read as ones in every implemented bit; a capture is pending so settings load after release.
    localparam state_t RST_ST = '{
        load: 1'b1,
        c3: cfg_fuse_pkg::CFG3_RESET,
        c4: cfg_fuse_pkg::CFG4_RESET,
        c5: cfg_fuse_pkg::CFG5_RESET,
        wdt_mode: cfg_fuse_pkg::WDT_OFF,
        pu: cfg_fuse_pkg::PU_IDLE,
        default: '0
    };

    state_t st;
    state_t next_st;
    logic [22:0] pu_limit;

    // ----------------------------------------
    // Power-up timer length
    // ----------------------------------------
    // Lengths are parameters so that a simulation can run with short counts.
    always_comb begin
        case (st.put_sel)
            cfg_fuse_pkg::PUT_LONG: pu_limit = 23'(PUT_LONG_CYCLES);
            cfg_fuse_pkg::PUT_MID: pu_limit = 23'(PUT_MID_CYCLES);
            default: pu_limit = 23'(PUT_SHORT_CYCLES);
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.load = PROG_DONE;

        // Programmer writes land in the byte store only; decode follows on the
        // next capture, so a half-written set never reaches the core.
        if (PROG_WE) begin
            case (PROG_ADDR)
                cfg_fuse_pkg::ADDR_CFG3: next_st.c3 = PROG_WDATA[5:0];
                cfg_fuse_pkg::ADDR_CFG4: begin
                    next_st.c4 = PROG_WDATA & cfg_fuse_pkg::CFG4_MASK;
                    if (PROG_LV_ACTIVE && st.c4[cfg_fuse_pkg::B4_LVPROG]) begin
                        next_st.c4[cfg_fuse_pkg::B4_LVPROG] = 1'b1;
                    end
                end
                cfg_fuse_pkg::ADDR_CFG5: next_st.c5 = PROG_WDATA & cfg_fuse_pkg::CFG5_MASK;
                default: ;
            endcase
        end

        // Read-back of the byte store, one cycle after the address.
        case (PROG_ADDR)
            cfg_fuse_pkg::ADDR_CFG3: next_st.rdata = {2'h0, st.c3};
            cfg_fuse_pkg::ADDR_CFG4: next_st.rdata = st.c4;
            cfg_fuse_pkg::ADDR_CFG5: next_st.rdata = st.c5;
            default: next_st.rdata = 8'h00;
        endcase

        // Capture decoded fields only at reset release or end of programming.
        if (st.load) begin
            next_st.lp_bor_n = st.c3[cfg_fuse_pkg::B3_LPBOR];
            next_st.vt_1way = st.c3[cfg_fuse_pkg::B3_VT1W];
            next_st.mvec = st.c3[cfg_fuse_pkg::B3_MVEC];
            next_st.put_sel = st.c3[cfg_fuse_pkg::B3_PUT +: 2];
            next_st.rst_pin_en = st.c3[cfg_fuse_pkg::B3_RSTPIN];
            next_st.isa_dis = st.c4[cfg_fuse_pkg::B4_ISA_OFF];
            next_st.lv_prog = st.c4[cfg_fuse_pkg::B4_LVPROG];
            next_st.stk_rst = st.c4[cfg_fuse_pkg::B4_STK];
            next_st.ps_1way = st.c4[cfg_fuse_pkg::B4_PS1W];
            next_st.zc_dis = st.c4[cfg_fuse_pkg::B4_ZC];
            next_st.bor_sel = st.c4[cfg_fuse_pkg::B4_BOR +: 2];
            next_st.wdt_mode = cfg_fuse_pkg::wdt_mode_t'(st.c5[cfg_fuse_pkg::B5_WDMODE +: 2]);
            next_st.cps = st.c5[4:0];
            if (st.c5[4:0] == cfg_fuse_pkg::WDT_CPS_SOFT) begin
                next_st.wps = cfg_fuse_pkg::WDT_PS_DEFAULT;
                next_st.ps_sw_ok = 1'b1;
            end else begin
                next_st.wps = st.c5[4:0];
                next_st.ps_sw_ok = 1'b0;
            end
        end else if (WATCHDOG_PERIOD_WE && st.ps_sw_ok) begin
            next_st.wps = WATCHDOG_PERIOD_WDATA;
        end

        // Prescale follows the software field when it is free, else the code.
        if (st.ps_sw_ok) begin
            next_st.ps_log2 = cfg_fuse_pkg::wdt_log2(st.wps);
        end else begin
            next_st.ps_log2 = cfg_fuse_pkg::wdt_log2(st.cps);
        end

        // Power-up timer runs after reset and again after each recapture, using the
        // captured selection; otherwise a reset store would always leave it disabled.
        next_st.pu_cnt = st.pu_cnt;
        case (st.pu)
            cfg_fuse_pkg::PU_IDLE: begin
                if (!st.load) begin
                    if (st.put_sel == cfg_fuse_pkg::PUT_OFF) begin
                        next_st.pu = cfg_fuse_pkg::PU_DONE;
                    end else begin
                        next_st.pu = cfg_fuse_pkg::PU_COUNT;
                        next_st.pu_cnt = 23'h000001;
                    end
                end
            end
            cfg_fuse_pkg::PU_COUNT: begin
                if (st.load) begin
                    next_st.pu = cfg_fuse_pkg::PU_IDLE;
                end else if (st.pu_cnt >= pu_limit) begin
                    next_st.pu = cfg_fuse_pkg::PU_DONE;
                end else begin
                    next_st.pu_cnt = st.pu_cnt + 23'h000001;
                end
            end
            cfg_fuse_pkg::PU_DONE: begin
                if (st.load) begin
                    next_st.pu = cfg_fuse_pkg::PU_IDLE;
                end
            end
            default: next_st.pu = cfg_fuse_pkg::PU_IDLE;
        endcase

        // Decoded outputs, each registered.
        next_st.lp_bor_on = !st.lp_bor_n;
        next_st.dispatch = st.mvec;
        next_st.rst_is_rst = st.lv_prog || st.rst_pin_en;
        next_st.hv_req = !st.lv_prog;
        next_st.isa_on = !st.isa_dis;
        next_st.stk_pulse = STACK_FAULT && st.stk_rst;
        // The module-disable bit only matters when software owns the detector.
        next_st.zc_on = st.zc_dis ? (ZERO_CROSS_SW_ENABLE && !ZERO_CROSS_MODULE_DISABLE)
                                  : 1'b1;
        case (st.bor_sel)
            2'h3: next_st.bor_mv = cfg_fuse_pkg::BOR_MV_3;
            2'h2: next_st.bor_mv = cfg_fuse_pkg::BOR_MV_2;
            2'h1: next_st.bor_mv = cfg_fuse_pkg::BOR_MV_1;
            default: next_st.bor_mv = cfg_fuse_pkg::BOR_MV_0;
        endcase
        case (st.wdt_mode)
            cfg_fuse_pkg::WDT_ALWAYS: next_st.wdt_run = 1'b1;
            cfg_fuse_pkg::WDT_AWAKE: next_st.wdt_run = !SLEEP;
            cfg_fuse_pkg::WDT_SOFT: next_st.wdt_run = WATCHDOG_SW_ENABLE;
            default: next_st.wdt_run = 1'b0;
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            st <= RST_ST;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Lock bits
    // ----------------------------------------
    // Both locks share the one-way cell; the one-way choice is the captured bit.
    cfg_lock_cell u_vector_lock (
        .clk(MCLK),
        .rst_b(RST_B),
        .one_way(st.vt_1way),
        .unlock(VECTOR_UNLOCK),
        .wr(VECTOR_LOCK_WE),
        .wdata(VECTOR_LOCK_WDATA),
        .lock(VECTOR_TABLE_LOCK)
    );

    cfg_lock_cell u_pinselect_lock (
        .clk(MCLK),
        .rst_b(RST_B),
        .one_way(st.ps_1way),
        .unlock(PINSELECT_UNLOCK),
        .wr(PINSELECT_LOCK_WE),
        .wdata(PINSELECT_LOCK_WDATA),
        .lock(PINSELECT_LOCK)
    );

    // Outputs taken straight from the state register.
    assign PROG_RDATA = st.rdata;
    assign LOW_POWER_BROWNOUT_ON = st.lp_bor_on;
    assign VECTOR_DISPATCH = st.dispatch;
    assign POWERUP_TIMER_DONE = st.pu[2];
    assign RESET_PIN_IS_RESET = st.rst_is_rst;
    assign HV_ENTRY_REQUIRED = st.hv_req;
    assign EXTENDED_ISA_ON = st.isa_on;
    assign STACK_FAULT_RESET = st.stk_pulse;
    assign ZERO_CROSS_ON = st.zc_on;
    assign BROWNOUT_MV = st.bor_mv;
    assign WATCHDOG_RUN = st.wdt_run;
    assign WATCHDOG_PERIOD_SW = st.wps;
    assign WATCHDOG_PS_SW_OK = st.ps_sw_ok;
    assign WATCHDOG_PRESCALE_LOG2 = st.ps_log2;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_load_soft;
        st.load && (st.c5[4:0] == cfg_fuse_pkg::WDT_CPS_SOFT);
    endsequence

    sequence s_soft_ready;
        (WATCHDOG_PERIOD_SW == cfg_fuse_pkg::WDT_PS_DEFAULT) && WATCHDOG_PS_SW_OK;
    endsequence

    property p_lp_bor;
        @(posedge MCLK) disable iff (!RST_B)
        st.load |=> ##1 (LOW_POWER_BROWNOUT_ON == !$past(st.c3[5], 2));
    endproperty
    a_lp_bor: assert property (p_lp_bor) else $error("low-power brown-out decode wrong");

    property p_lv_hold;
        @(posedge MCLK) disable iff (!RST_B)
        (PROG_WE && PROG_ADDR == cfg_fuse_pkg::ADDR_CFG4 && PROG_LV_ACTIVE && st.c4[5])
            |=> st.c4[5];
    endproperty
    a_lv_hold: assert property (p_lv_hold) else $error("low-voltage bit cleared in session");

    property p_reset_pin;
        @(posedge MCLK) disable iff (!RST_B)
        (st.lv_prog && !st.load) |=> RESET_PIN_IS_RESET && !HV_ENTRY_REQUIRED;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("shared pin not reset");

    property p_wdt_off;
        @(posedge MCLK) disable iff (!RST_B)
        (st.wdt_mode == cfg_fuse_pkg::WDT_OFF) |=> !WATCHDOG_RUN;
    endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("watchdog runs while off");

    property p_period_locked;
        @(posedge MCLK) disable iff (!RST_B)
        (!st.ps_sw_ok && !st.load) |=> $stable(WATCHDOG_PERIOD_SW);
    endproperty
    a_period_locked: assert property (p_period_locked) else $error("locked period moved");

    property p_period_soft;
        @(posedge MCLK) disable iff (!RST_B)
        s_load_soft |=> s_soft_ready;
    endproperty
    a_period_soft: assert property (p_period_soft) else $error("soft period not defaulted");

    property p_stack;
        @(posedge MCLK) disable iff (!RST_B)
        STACK_FAULT |=> (STACK_FAULT_RESET == $past(st.stk_rst));
    endproperty
    a_stack: assert property (p_stack) else $error("stack fault reset wrong");

    property p_reserved_band;
        @(posedge MCLK) disable iff (!RST_B)
        (!st.load && !st.ps_sw_ok && st.cps > cfg_fuse_pkg::WDT_CPS_MAX_DIRECT)
            |=> (WATCHDOG_PRESCALE_LOG2 == cfg_fuse_pkg::WDT_LOG2_MIN);
    endproperty
    a_reserved_band: assert property (p_reserved_band) else $error("reserved band not 1:32");
endmodule // config_fuse_decode
`default_nettype wire

// ### tb/config_fuse_decode_bench.sv
// Self-checking testbench for the configuration fuse decoder.
`timescale 1ns/1ps
`default_nettype none
module config_fuse_decode_bench;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic MCLK = 1'b0, RST_B = 1'b0, PROG_WE = 1'b0, PROG_LV_ACTIVE = 1'b0, PROG_DONE = 1'b0;
    logic [21:0] PROG_ADDR = 22'h0;
    logic [7:0] PROG_WDATA = 8'h0;
    logic [4:0] WATCHDOG_PERIOD_WDATA = 5'h0;
    logic SLEEP = 1'b0, WATCHDOG_SW_ENABLE = 1'b0, WATCHDOG_PERIOD_WE = 1'b0;
    logic VECTOR_UNLOCK = 1'b0, VECTOR_LOCK_WE = 1'b0, VECTOR_LOCK_WDATA = 1'b0;
    logic PINSELECT_UNLOCK = 1'b0, PINSELECT_LOCK_WE = 1'b0, PINSELECT_LOCK_WDATA = 1'b0;
    logic ZERO_CROSS_SW_ENABLE = 1'b0, ZERO_CROSS_MODULE_DISABLE = 1'b0, STACK_FAULT = 1'b0;
    logic [7:0] PROG_RDATA;
    logic LOW_POWER_BROWNOUT_ON, VECTOR_TABLE_LOCK, PINSELECT_LOCK, VECTOR_DISPATCH;
    logic POWERUP_TIMER_DONE, RESET_PIN_IS_RESET, HV_ENTRY_REQUIRED, EXTENDED_ISA_ON;
    logic STACK_FAULT_RESET, ZERO_CROSS_ON, WATCHDOG_RUN, WATCHDOG_PS_SW_OK;
    logic [11:0] BROWNOUT_MV;
    logic [4:0] WATCHDOG_PERIOD_SW, WATCHDOG_PRESCALE_LOG2;
    int bad_count = 0;
    int num_checks = 0;
    string scen = "";
    localparam logic [21:0] A3 = cfg_fuse_pkg::ADDR_CFG3;
    localparam logic [21:0] A4 = cfg_fuse_pkg::ADDR_CFG4;
    localparam logic [21:0] A5 = cfg_fuse_pkg::ADDR_CFG5;

    // Short power-up counts keep the run brief.
    config_fuse_decode #(.PUT_LONG_CYCLES(40), .PUT_MID_CYCLES(20), .PUT_SHORT_CYCLES(10))
        dut_u (.*);

    // Free-running 100 MHz clock.
    always #5 MCLK = ~MCLK;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Inputs always move 1 ns after the edge, so no race with the design's flops.
    task automatic step(input int n = 1);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t in %s: saw %h expected %h", $time, scen, seen, exp);
        end
    endtask

    task automatic wr(input logic [21:0] a, input logic [7:0] d);
        PROG_ADDR = a;
        PROG_WDATA = d;
        PROG_WE = 1'b1;
        step();
        PROG_WE = 1'b0;
        // Let an edge pass so a following write never lowers and raises the strobe at once.
        step();
    endtask

    // Read data is registered, so two edges pass before sampling.
    task automatic rd(input logic [21:0] a, input logic [7:0] e);
        PROG_ADDR = a;
        step(2);
        chk(PROG_RDATA, e);
    endtask

    // Decoded outputs move two edges after the end-of-programming pulse.
    task automatic done();
        PROG_DONE = 1'b1;
        step();
        PROG_DONE = 1'b0;
        step(2);
    endtask

    // Counts cycles from the return of done() until the power-up timer expires.
    task automatic put_wait(input int exp);
        int n;
        for (n = 0; n < 100 && POWERUP_TIMER_DONE !== 1'b1; n++) step();
        chk(12'(n), 12'(exp));
        if (n == 100) report_and_stop();
    endtask

    // Optional unlock pulse, then one lock write, then the lock is judged.
    task automatic lk(input bit pin, input bit unl, input bit v, input bit e);
        if (pin) PINSELECT_UNLOCK = unl;
        else VECTOR_UNLOCK = unl;
        step();
        PINSELECT_UNLOCK = 1'b0;
        VECTOR_UNLOCK = 1'b0;
        if (pin) begin
            PINSELECT_LOCK_WE = 1'b1;
            PINSELECT_LOCK_WDATA = v;
        end else begin
            VECTOR_LOCK_WE = 1'b1;
            VECTOR_LOCK_WDATA = v;
        end
        step();
        PINSELECT_LOCK_WE = 1'b0;
        VECTOR_LOCK_WE = 1'b0;
        step();
        chk(pin ? PINSELECT_LOCK : VECTOR_TABLE_LOCK, e);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        int i;
        scen = "reset";
        rd(A3, 8'h3f);
        rd(A4, 8'hbf);
        rd(A5, 8'h7f);
        rd(22'h30_0005, 8'h00);
        for (i = 0; i < 100 && POWERUP_TIMER_DONE !== 1'b1; i++) step();
        chk(POWERUP_TIMER_DONE, 1);
        if (i == 100) report_and_stop();
        chk(LOW_POWER_BROWNOUT_ON, 0);
        chk(VECTOR_DISPATCH, 1);
        chk(RESET_PIN_IS_RESET, 1);
        chk(HV_ENTRY_REQUIRED, 0);
        chk(EXTENDED_ISA_ON, 0);
        chk(BROWNOUT_MV, 12'h76c);
        chk(WATCHDOG_RUN, 1);
        chk(WATCHDOG_PERIOD_SW, 5'h0b);
    endtask

    // Settings hold until recapture; with low-voltage entry on, the pin stays reset.
    task automatic t_cfg3();
        scen = "cfg3";
        wr(A3, 8'h00);
        step(3);
        chk(LOW_POWER_BROWNOUT_ON, 0);
        done();
        chk(LOW_POWER_BROWNOUT_ON, 1);
        chk(VECTOR_DISPATCH, 0);
        chk(RESET_PIN_IS_RESET, 1);
        chk(POWERUP_TIMER_DONE, 0);
        put_wait(10);
    endtask

    task automatic t_lvp();
        scen = "lvp";
        PROG_LV_ACTIVE = 1'b1;
        wr(A4, 8'h1f);
        PROG_LV_ACTIVE = 1'b0;
        rd(A4, 8'h3f);
        wr(A4, 8'h1f);
        rd(A4, 8'h1f);
        done();
        chk(HV_ENTRY_REQUIRED, 1);
        chk(RESET_PIN_IS_RESET, 0);
        wr(A3, 8'h05);
        done();
        chk(RESET_PIN_IS_RESET, 1);
        put_wait(40);
    endtask

    task automatic t_cfg4();
        logic [11:0] mv[4] = '{12'hb22, 12'ha8c, 12'h992, 12'h76c};
        scen = "cfg4";
        for (int k = 0; k < 4; k++) begin
            wr(A4, 8'h38 | 8'(k));
            done();
            chk(BROWNOUT_MV, mv[k]);
        end
        chk(EXTENDED_ISA_ON, 1);
        ZERO_CROSS_MODULE_DISABLE = 1'b1;
        step(2);
        chk(ZERO_CROSS_ON, 1);
        STACK_FAULT = 1'b1;
        step();
        STACK_FAULT = 1'b0;
        chk(STACK_FAULT_RESET, 1);
        step();
        chk(STACK_FAULT_RESET, 0);
        wr(A4, 8'ha4);
        done();
        chk(EXTENDED_ISA_ON, 0);
        chk(ZERO_CROSS_ON, 0);
        ZERO_CROSS_SW_ENABLE = 1'b1;
        ZERO_CROSS_MODULE_DISABLE = 1'b0;
        step(2);
        chk(ZERO_CROSS_ON, 1);
        STACK_FAULT = 1'b1;
        step();
        STACK_FAULT = 1'b0;
        chk(STACK_FAULT_RESET, 0);
    endtask

    // Both one-way settings of both locks, a write without unlock among them.
    task automatic t_locks();
        scen = "locks";
        lk(1, 0, 1, 0);
        lk(1, 1, 1, 1);
        lk(1, 1, 0, 0);
        lk(0, 1, 1, 1);
        lk(0, 1, 0, 0);
        wr(A3, 8'h13);
        wr(A4, 8'hac);
        done();
        put_wait(20);
        lk(0, 1, 0, 0);
        lk(0, 1, 1, 1);
        lk(0, 1, 0, 1);
        lk(1, 1, 1, 1);
        lk(1, 1, 0, 1);
    endtask

    task automatic t_wdt();
        logic e;
        scen = "watchdog mode";
        for (int m = 0; m < 4; m++) begin
            wr(A5, {1'b0, 2'(m), 5'h1f});
            done();
            for (int s = 0; s < 4; s++) begin
                SLEEP = s[1];
                WATCHDOG_SW_ENABLE = s[0];
                step(2);
                e = (m == 3) ? 1'b1 : (m == 2) ? !s[1] : (m == 1) ? s[0] : 1'b0;
                chk(WATCHDOG_RUN, e);
            end
        end
        SLEEP = 1'b0;
    endtask

    // Period codes at each band edge, then a software write to the field.
    task automatic t_period();
        logic [4:0] cs[5] = '{5'h00, 5'h12, 5'h13, 5'h1e, 5'h1f};
        logic [4:0] c, f, g;
        logic ok;
        scen = "watchdog period";
        foreach (cs[j]) begin
            c = cs[j];
            ok = (c == 5'h1f);
            f = ok ? 5'h0b : c;
            g = (c <= 5'h12) ? c + 5'h05 : ok ? 5'h10 : 5'h05;
            wr(A5, {3'h3, c});
            done();
            chk(WATCHDOG_PERIOD_SW, f);
            chk(WATCHDOG_PS_SW_OK, ok);
            chk(WATCHDOG_PRESCALE_LOG2, g);
            WATCHDOG_PERIOD_WDATA = 5'h03;
            WATCHDOG_PERIOD_WE = 1'b1;
            step();
            WATCHDOG_PERIOD_WE = 1'b0;
            step();
            chk(WATCHDOG_PERIOD_SW, ok ? 5'h03 : f);
            chk(WATCHDOG_PRESCALE_LOG2, ok ? 5'h08 : g);
        end
    endtask

    // A reset in mid-run restores the stored bytes and clears the locks.
    task automatic t_rerst();
        scen = "second reset";
        RST_B = 1'b0;
        step(2);
        chk(VECTOR_TABLE_LOCK, 0);
        RST_B = 1'b1;
        step(3);
        rd(A5, 8'h7f);
        chk(WATCHDOG_PERIOD_SW, 5'h0b);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        step(10);
        RST_B = 1'b1;
        t_reset();
        t_cfg3();
        t_lvp();
        t_cfg4();
        t_locks();
        t_wdt();
        t_period();
        t_rerst();
        report_and_stop();
    end
endmodule // config_fuse_decode_bench
`default_nettype wire
